// ---- adc_ctrl_defs.vh ----
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// register byte offsets on the wishbone bus
`define REG_TRIG_SCAN_CTRL    4'h0
`define REG_START_CTRL        4'h4
`define REG_STATUS            4'h8

// trigger/scan/clock control field positions
`define FLD_TRGS_HI           7
`define FLD_TRGS_LO           6
`define FLD_SCAN_EN           5
`define FLD_SCAN_SIZE         4
`define FLD_CKS_HI            3
`define FLD_CKS_LO            2
`define CTRL_WRITABLE_MASK    8'hFC
`define CTRL_RESET            8'h00

// start/channel control field positions
`define FLD_START             0
`define FLD_CHAN_HI           3
`define FLD_CHAN_LO           1
`define START_RESET           8'h00

// status field positions
`define FLD_STAT_BUSY         0
`define FLD_STAT_CHAN_HI      3
`define FLD_STAT_CHAN_LO      1
`define FLD_STAT_DONE_SEEN    4

// trigger source codes
`define TRG_NONE              2'h0
`define TRG_MTU               2'h1
`define TRG_TMR8              2'h2
`define TRG_PIN               2'h3

// conversion clock select codes
`define CKS_SLOWEST           2'h0
`define CKS_SLOW              2'h1
`define CKS_FAST              2'h2
`define CKS_FASTEST           2'h3

// conversion times in states (maximum), one state per system clock
`define CONV_STATES_0         530
`define CONV_STATES_1         266
`define CONV_STATES_2         134
`define CONV_STATES_3         68
`define STATE_PERIOD_NS       10
`define CLK_PERIOD_NS         10
`define CONV_CYC_0            ((`CONV_STATES_0 * `STATE_PERIOD_NS) / `CLK_PERIOD_NS)
`define CONV_CYC_1            ((`CONV_STATES_1 * `STATE_PERIOD_NS) / `CLK_PERIOD_NS)
`define CONV_CYC_2            ((`CONV_STATES_2 * `STATE_PERIOD_NS) / `CLK_PERIOD_NS)
`define CONV_CYC_3            ((`CONV_STATES_3 * `STATE_PERIOD_NS) / `CLK_PERIOD_NS)

// scan sizes
`define SCAN_LAST_SMALL       3'h3
`define SCAN_LAST_LARGE       3'h7

`endif

// ---- adc_trigger_select.v ----
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module adc_trigger_select (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [1:0] trigger_source_select_i,
  input  wire       timer_mtu_trig_i,
  input  wire       timer_8bit_trig_i,
  input  wire       ext_trig_n_i,
  output reg        trigger_o
);

  reg ext_meta;
  reg ext_sync;
  reg ext_prev;

  // pin is asynchronous: two flops before any logic looks at it
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
      ext_prev <= 1'b1;
    end else begin
      ext_meta <= ext_trig_n_i;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // one pulse per selected source event; pin triggers on its falling edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      trigger_o <= 1'b0;
    end else begin
      case (trigger_source_select_i)
        `TRG_NONE: trigger_o <= 1'b0;
        `TRG_MTU:  trigger_o <= timer_mtu_trig_i;
        `TRG_TMR8: trigger_o <= timer_8bit_trig_i;
        `TRG_PIN:  trigger_o <= ext_prev & ~ext_sync;
        default:   trigger_o <= 1'b0;
      endcase
    end
  end

endmodule

// ---- adc_conv_timer.v ----
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module adc_conv_timer #(
  parameter CW = 10
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       launch_i,
  input  wire       abort_i,
  input  wire [1:0] clock_select_i,
  output reg        done_o
);

  reg [CW-1:0] remaining;
  reg          running;
  reg [CW-1:0] load_value;

  // window lengths sized to the counter, so no silent truncation on load
  localparam [CW-1:0] LOAD_0 = `CONV_CYC_0;
  localparam [CW-1:0] LOAD_1 = `CONV_CYC_1;
  localparam [CW-1:0] LOAD_2 = `CONV_CYC_2;
  localparam [CW-1:0] LOAD_3 = `CONV_CYC_3;

  // conversion length per clock select code
  always @* begin
    case (clock_select_i)
      `CKS_SLOWEST: load_value = LOAD_0;
      `CKS_SLOW:    load_value = LOAD_1;
      `CKS_FAST:    load_value = LOAD_2;
      `CKS_FASTEST: load_value = LOAD_3;
      default:      load_value = LOAD_0;
    endcase
  end

  // done pulses on the last cycle of the window so the total equals the figure
  always @(posedge clk_i) begin
    if (rst_i) begin
      remaining <= {CW{1'b0}};
      running   <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        running <= 1'b0;
      end else if (launch_i) begin
        remaining <= load_value - {{(CW-1){1'b0}}, 1'b1};
        running   <= 1'b1;
      end else if (running) begin
        if (remaining == {{(CW-1){1'b0}}, 1'b1}) begin
          done_o  <= 1'b1;
          running <= 1'b0;
        end else begin
          remaining <= remaining - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ---- adc_control_top.v ----
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module adc_control_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        timer_mtu_trig_i,
  input  wire        timer_8bit_trig_i,
  input  wire        ext_trig_n_i,
  output reg         sample_start_o,
  output reg  [2:0]  channel_o,
  output reg         conversion_busy_o,
  output reg         conversion_done_o
);

  localparam ST_IDLE    = 1'b0;
  localparam ST_CONVERT = 1'b1;

  // register storage
  reg  [7:0] converter_trigger_scan_control;
  reg        conversion_start_flag;
  reg  [2:0] single_channel;
  reg        done_seen;
  reg        state;
  reg  [2:0] current_channel;
  reg        launch;

  wire [1:0] trigger_sel;
  wire       scan_enable_bit;
  wire       scan_size_bit;
  wire [1:0] clock_sel;
  wire       trigger_event;
  wire       timer_done;

  // bus decode
  wire       bus_req;
  wire       wr_lane0;
  wire       wr_ctrl;
  wire       wr_start;
  wire       sw_start;
  wire       sw_stop;
  wire [2:0] scan_last;
  reg  [7:0] read_byte;
  wire [7:0] next_ctrl;
  wire [7:0] ctrl_bit_we;
  genvar     b;

  // sequencer and start flag next values
  reg        next_state;
  reg  [2:0] next_channel;
  reg        next_launch;
  reg        next_start_flag;

  // conversion events
  wire       channel_done;
  wire       group_wrap;
  wire       abort_run;

  // writable bits of the control byte, as a per-bit vector
  localparam [7:0] CTRL_WRITABLE = `CTRL_WRITABLE_MASK;

  assign trigger_sel     = converter_trigger_scan_control[`FLD_TRGS_HI:`FLD_TRGS_LO];
  assign scan_enable_bit = converter_trigger_scan_control[`FLD_SCAN_EN];
  assign scan_size_bit   = converter_trigger_scan_control[`FLD_SCAN_SIZE];
  assign clock_sel       = converter_trigger_scan_control[`FLD_CKS_HI:`FLD_CKS_LO];

  // one access per request; ack is dropped the cycle after it was given
  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_ctrl  = wr_lane0 & (wb_adr_i == `REG_TRIG_SCAN_CTRL);
  assign wr_start = wr_lane0 & (wb_adr_i == `REG_START_CTRL);
  assign sw_start = wr_start & wb_dat_i[`FLD_START];
  assign sw_stop  = wr_start & ~wb_dat_i[`FLD_START];

  // last channel of a scan group, 4 or 8 channels
  assign scan_last = scan_size_bit ? `SCAN_LAST_LARGE : `SCAN_LAST_SMALL;
  assign group_wrap = (current_channel >= scan_last);

  // a channel finishes only while the sequencer is converting
  assign channel_done = timer_done & (state == ST_CONVERT);

  // software stop cuts the running channel short instead of letting it end
  assign abort_run = (state == ST_CONVERT) & ~conversion_start_flag;

  // trigger source multiplexer with pin synchroniser
  adc_trigger_select u_trigger (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .trigger_source_select_i (trigger_sel),
    .timer_mtu_trig_i        (timer_mtu_trig_i),
    .timer_8bit_trig_i       (timer_8bit_trig_i),
    .ext_trig_n_i            (ext_trig_n_i),
    .trigger_o               (trigger_event)
  );

  // per-channel conversion time
  adc_conv_timer #(
    .CW (10)
  ) u_timer (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .launch_i       (launch),
    .abort_i        (abort_run),
    .clock_select_i (clock_sel),
    .done_o         (timer_done)
  );

  // next control byte, bit by bit: reserved bits never load, clock select is
  // locked while a conversion runs so the timer never sees its length change
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_ctrl_bit
      if (b == `FLD_CKS_HI || b == `FLD_CKS_LO) begin : g_locked
        assign ctrl_bit_we[b] = wr_ctrl & ~conversion_start_flag;
      end else begin : g_open
        assign ctrl_bit_we[b] = wr_ctrl & CTRL_WRITABLE[b];
      end
      assign next_ctrl[b] = ctrl_bit_we[b] ? wb_dat_i[b] : converter_trigger_scan_control[b];
    end
  endgenerate

  // control register
  always @(posedge clk_i) begin
    if (rst_i) begin
      converter_trigger_scan_control <= `CTRL_RESET;
    end else begin
      converter_trigger_scan_control <= next_ctrl;
    end
  end

  // single-mode channel, loaded by every write to the start register
  always @(posedge clk_i) begin
    if (rst_i) begin
      single_channel <= 3'h0;
    end else if (wr_start) begin
      single_channel <= wb_dat_i[`FLD_CHAN_HI:`FLD_CHAN_LO];
    end
  end

  // start flag: a hardware set (trigger) wins over a software clear
  always @* begin
    next_start_flag = conversion_start_flag;
    if (trigger_event || sw_start) begin
      next_start_flag = 1'b1;
    end else if (sw_stop) begin
      next_start_flag = 1'b0;
    end else if (channel_done && !scan_enable_bit) begin
      next_start_flag = 1'b0;
    end
  end

  // start flag register
  always @(posedge clk_i) begin
    if (rst_i) begin
      conversion_start_flag <= 1'b0;
    end else begin
      conversion_start_flag <= next_start_flag;
    end
  end

  // sequencer: single mode converts one channel, scan mode loops the group
  always @* begin
    next_state   = state;
    next_channel = current_channel;
    next_launch  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (conversion_start_flag) begin
          next_state   = ST_CONVERT;
          next_launch  = 1'b1;
          next_channel = scan_enable_bit ? 3'h0 : single_channel;
        end
      end
      ST_CONVERT: begin
        if (!conversion_start_flag) begin
          next_state = ST_IDLE;
        end else if (timer_done) begin
          if (scan_enable_bit) begin
            next_launch = 1'b1;
            if (group_wrap) begin
              next_channel = 3'h0;
            end else begin
              next_channel = current_channel + 3'h1;
            end
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      state           <= ST_IDLE;
      current_channel <= 3'h0;
      launch          <= 1'b0;
    end else begin
      state           <= next_state;
      current_channel <= next_channel;
      launch          <= next_launch;
    end
  end

  // analog-side outputs, all registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      sample_start_o    <= 1'b0;
      channel_o         <= 3'h0;
      conversion_busy_o <= 1'b0;
      conversion_done_o <= 1'b0;
    end else begin
      sample_start_o    <= launch;
      channel_o         <= current_channel;
      conversion_busy_o <= (state == ST_CONVERT);
      conversion_done_o <= channel_done;
    end
  end

  // sticky done for software: a finishing channel wins over the clearing write
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_seen <= 1'b0;
    end else if (channel_done) begin
      done_seen <= 1'b1;
    end else if (wr_start) begin
      done_seen <= 1'b0;
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    read_byte = 8'h00;
    case (wb_adr_i)
      `REG_TRIG_SCAN_CTRL: begin
        read_byte = converter_trigger_scan_control;
      end
      `REG_START_CTRL: begin
        read_byte = {4'h0, single_channel, conversion_start_flag};
      end
      `REG_STATUS: begin
        read_byte = {3'h0, done_seen, current_channel, (state == ST_CONVERT)};
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
  end

  // wishbone answer one cycle after the request, every address acknowledged
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // read data captured with the request, held until the next read
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= {24'h000000, read_byte};
    end
  end

endmodule

// ---- adc_control_monitor.sv ----
`timescale 1ns/1ps
module adc_control_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        timer_mtu_trig_i,
  input wire        timer_8bit_trig_i,
  input wire        ext_trig_n_i,
  input wire        sample_start_o,
  input wire [2:0]  channel_o,
  input wire        conversion_busy_o,
  input wire        conversion_done_o
);
  reg [1:0] tsel;
  reg       scan_en;
  reg       scan_sz;
  reg [9:0] cnt;
  wire      wr0 = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0 && wb_sel_i[0];
  // shadow of the mode fields, taken on the same edge as the register
  always @(posedge clk_i) begin
    if (rst_i) begin
      tsel <= 2'h0;
      scan_en <= 1'b0;
      scan_sz <= 1'b0;
    end else if (wr0) begin
      tsel <= wb_dat_i[7:6];
      scan_en <= wb_dat_i[5];
      scan_sz <= wb_dat_i[4];
    end
  end
  // cycles since channel start, saturates so aborted runs cannot wrap
  always @(posedge clk_i) begin
    if (rst_i || sample_start_o)
      cnt <= 10'h001;
    else if (cnt != 10'h3FF)
      cnt <= cnt + 10'h001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence quiet_idle;
    tsel == 2'h0 && !wb_cyc_i && !conversion_busy_o;
  endsequence
  sequence run_end;
    conversion_done_o && !wb_cyc_i && !$past(wb_cyc_i);
  endsequence
  AST_NO_TRIG: assert property (quiet_idle [*6] |=> !$rose(conversion_busy_o))
    else $error("conversion began with triggers disabled");
  AST_MTU_START: assert property ((tsel == 2'h1 && timer_mtu_trig_i && !conversion_busy_o
    && !wb_cyc_i) |-> ##[1:6] conversion_busy_o) else $error("timer trigger not taken");
  AST_TMR8_START: assert property ((tsel == 2'h2 && timer_8bit_trig_i && !conversion_busy_o
    && !wb_cyc_i) |-> ##[1:6] conversion_busy_o) else $error("8-bit timer trigger not taken");
  AST_PIN_START: assert property ((tsel == 2'h3 && $fell(ext_trig_n_i) && !conversion_busy_o
    && !wb_cyc_i) |-> ##[1:10] conversion_busy_o) else $error("pin trigger not taken");
  AST_SINGLE_END: assert property ((!scan_en && conversion_done_o)
    |-> ##[0:2] !conversion_busy_o) else $error("single mode did not stop");
  AST_SCAN_RANGE: assert property ((scan_en && sample_start_o)
    |-> channel_o <= (scan_sz ? 3'h7 : 3'h3)) else $error("scan channel out of range");
  AST_SCAN_RELAUNCH: assert property ((scan_en and run_end) |-> ##[0:2] sample_start_o)
    else $error("scan did not continue");
  AST_CONV_TIME: assert property (conversion_done_o
    |-> cnt inside {10'h212, 10'h10A, 10'h086, 10'h044}) else $error("bad conversion time");
  AST_RSVD_ZERO: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == 4'h0)
    |-> wb_dat_o[7:0] == {tsel, scan_en, scan_sz, wb_dat_o[3:2], 2'h0})
    else $error("control readback wrong");
endmodule

// ---- adc_control_top_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module adc_control_top_tb_top;
  reg         clk_i;
  reg         rst_i;
  reg         wb_cyc_i;
  reg         wb_stb_i;
  reg         wb_we_i;
  reg  [3:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i;
  reg         timer_mtu_trig_i;
  reg         timer_8bit_trig_i;
  reg         ext_trig_n_i;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire        sample_start_o;
  wire [2:0]  channel_o;
  wire        conversion_busy_o;
  wire        conversion_done_o;
  integer     mismatches = 0;
  integer     n_compared = 0;
  integer     cycles = 0;
  integer     ct [0:3] = '{530, 266, 134, 68};
  integer     i, t, s, c, k;
  reg  [31:0] seed, rd;
  reg         got;
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  adc_control_top i_adc_control_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_mtu_trig_i(timer_mtu_trig_i),
    .timer_8bit_trig_i(timer_8bit_trig_i), .ext_trig_n_i(ext_trig_n_i),
    .sample_start_o(sample_start_o), .channel_o(channel_o),
    .conversion_busy_o(conversion_busy_o), .conversion_done_o(conversion_done_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task conclude;
    begin
      if (mismatches == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      conclude;
    end
  end
  // classic single cycle, held until ack is seen
  task bus(input [3:0] a, input w, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'h1;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task wait_ss;
    do @(posedge clk_i); while (sample_start_o !== 1'b1);
  endtask
  // one trigger event from source src, pin held low a few cycles
  task pulse(input integer src);
    begin
      @(posedge clk_i);
      timer_mtu_trig_i <= (src == 0);
      timer_8bit_trig_i <= (src == 1);
      ext_trig_n_i <= (src != 2);
      @(posedge clk_i);
      timer_mtu_trig_i <= 1'b0;
      timer_8bit_trig_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      ext_trig_n_i <= 1'b1;
    end
  endtask
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 43'h0};
    {timer_mtu_trig_i, timer_8bit_trig_i, ext_trig_n_i} = 3'h1;
    seed = 32'h6D7AF2E5;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(4'h0, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    seed = lfsr(seed);
    bus(4'h0, 1'b1, seed);
    bus(4'h0, 1'b0, 32'h0);
    `CHK(rd, {24'h0, seed[7:2], 2'h0})
    bus(4'hC, 1'b1, seed);
    bus(4'hC, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    // every trigger code against every source
    for (t = 0; t < 4; t++) begin
      for (s = 0; s < 3; s++) begin
        bus(4'h0, 1'b1, {24'h0, t[1:0], 6'h0C});
        pulse(s);
        got = 1'b0;
        repeat (12) begin
          @(posedge clk_i);
          got = got | conversion_busy_o;
        end
        `CHK(got, t == s + 1)
        bus(4'h4, 1'b1, 32'h0);
      end
    end
    // scan size set but scan off: one channel, timed per clock select
    for (c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      bus(4'h0, 1'b1, {24'h0, 4'h1, c[1:0], 2'h0});
      bus(4'h4, 1'b1, {28'h0, seed[2:0], 1'b1});
      wait_ss;
      `CHK(channel_o, seed[2:0])
      k = 0;
      do begin @(posedge clk_i); k++; end while (conversion_done_o !== 1'b1);
      `CHK(k, ct[c])
      repeat (3) @(posedge clk_i);
      `CHK(conversion_busy_o, 1'b0)
    end
    // clock select write during a run must not land
    bus(4'h0, 1'b1, 32'h0C);
    bus(4'h4, 1'b1, 32'h1);
    bus(4'h0, 1'b1, 32'h0);
    bus(4'h0, 1'b0, 32'h0);
    `CHK(rd[3:2], 2'h3)
    do @(posedge clk_i); while (conversion_done_o !== 1'b1);
    // scan over four then eight channels, wrapping
    for (s = 0; s < 2; s++) begin
      bus(4'h0, 1'b1, {26'h0, 1'b1, s[0], 4'hC});
      bus(4'h4, 1'b1, 32'h1);
      for (i = 0; i < 10; i++) begin
        wait_ss;
        `CHK(channel_o, s ? i[2:0] : {1'b0, i[1:0]})
      end
      bus(4'h4, 1'b1, 32'h0);
      repeat (3) @(posedge clk_i);
      `CHK(conversion_busy_o, 1'b0)
    end
    conclude;
  end
endmodule
bind adc_control_top adc_control_monitor i_adc_control_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_mtu_trig_i(timer_mtu_trig_i),
  .timer_8bit_trig_i(timer_8bit_trig_i), .ext_trig_n_i(ext_trig_n_i),
  .sample_start_o(sample_start_o), .channel_o(channel_o),
  .conversion_busy_o(conversion_busy_o), .conversion_done_o(conversion_done_o));
